// *** src/tmi_slave.sv ***
// two-wire slave port onto the tag's byte-addressed memory.
// assumes scl/sda arrive from pins (synchronised here) and that the pad
// turns sda_oe into an open-drain pull-down.
`timescale 1ns/1ps
`include "tmi_defines.svh"
module tmi_slave
  import tmi_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `TMI_PROG_CYCLES
) (
  input  wire logic clock,           // 50 MHz system clock
  input  wire logic sys_rst,         // sync reset, active high
  input  wire logic scl_in,          // bus clock pin level
  input  wire logic sda_in,          // bus data pin level
  output logic      sda_out,         // data pin drive value
  output logic      sda_oe,          // high while pulling data low
  input  wire logic dc_supply_input, // high while supply pin powered
  output logic      prog_busy        // high while programming memory
);

  // -----------------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------------
  logic [7:0]            mem [`TMI_MEM_BYTES];
  logic                  scl_s1, scl_s2, scl_d;
  logic                  sda_s1, sda_s2, sda_d;
  logic                  dc_s1, dc_s2;
  logic                  scl_rise, scl_fall, start_det, stop_det;
  tmi_bus_state_t        st;
  tmi_role_t             role;
  logic [3:0]            bitcnt;
  logic [7:0]            shreg;
  logic [7:0]            txb;
  logic                  rw;
  logic                  master_ack;
  logic [7:0]            ptr_hi;
  logic [`TMI_PTR_W-1:0] ptr;
  logic                  ptr_set;
  logic [2:0]            wcount;
  logic                  push_v;
  logic [7:0]            push_d;
  logic                  prog_req;
  logic                  flush_req;
  logic [`TMI_PTR_W-1:0] prog_base;
  logic [2:0]            prog_len;
  tmi_prog_state_t       pst;
  logic [2:0]            pidx;
  logic [23:0]           tcnt;
  logic [1:0]            addr_bits;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [7:0]            fifo_out_data;
  logic                  mem_we;
  logic [`TMI_PTR_W-1:0] mem_waddr;
  logic                  addr_match;
  logic                  len_ok;
  logic [`TMI_PTR_W-1:0] wr_base;
  logic [`TMI_PTR_W-1:0] new_ptr;
  logic [7:0]            rd_now;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  function automatic logic byte_writable(input logic [`TMI_PTR_W-1:0] a);
    byte_writable = (a <= `TMI_MEM_LAST)
                  & ~((a >= `TMI_CAL_FIRST) & (a <= `TMI_CAL_LAST))
                  & ~((a >= `TMI_ROM_FIRST) & (a <= `TMI_ROM_LAST));
  endfunction

  // no permission bits are looked at: lock and kill belong to the radio
  function automatic logic [7:0] read_byte(input logic [`TMI_PTR_W-1:0] a);
    read_byte = (a > `TMI_MEM_LAST) ? `TMI_BLANK_BYTE : mem[a];
  endfunction

  // saturates: once past the end every further byte is blank anyway
  function automatic logic [`TMI_PTR_W-1:0] ptr_inc(
    input logic [`TMI_PTR_W-1:0] a);
    ptr_inc = (a == `TMI_PTR_MAX) ? a : `TMI_PTR_W'(a + 1'b1);
  endfunction

  // -----------------------------------------------------------------------
  // pin synchronisers and bus events
  // -----------------------------------------------------------------------
  // edges are found purely from oversampled levels, no timeouts, so any
  // rate from a stopped clock up to fast mode works
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
      dc_s1  <= 1'b0;
      dc_s2  <= 1'b0;
    end
    else
    begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
      dc_s1  <= dc_supply_input;
      dc_s2  <= dc_s1;
    end
  end

  assign scl_rise  = scl_s2 & ~scl_d;
  assign scl_fall  = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // busy refuses the address, so a programming cycle is never disturbed
  assign addr_match = (shreg[7:1] == {`TMI_ADDR_HI, addr_bits, 1'b0})
                    & ~prog_busy & dc_s2;

  // -----------------------------------------------------------------------
  // write length check and aligned base
  // -----------------------------------------------------------------------
  assign len_ok  = (wcount == `TMI_ONE_WORD_BYTES)
                 | (wcount == `TMI_TWO_WORD_BYTES);
  assign wr_base = (wcount == `TMI_TWO_WORD_BYTES)
                 ? {ptr[`TMI_PTR_W-1:2], 2'b00}
                 : {ptr[`TMI_PTR_W-1:1], 1'b0};
  assign new_ptr = {ptr_hi[2:0], shreg};

  // byte at the stored pointer, ready before the next read byte starts
  always_comb
  begin
    rd_now = read_byte(ptr);
  end

  // -----------------------------------------------------------------------
  // bus byte engine
  // -----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st         <= TMI_ST_IDLE;
      role       <= TMI_ROLE_DEV;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      txb        <= 8'h00;
      rw         <= 1'b0;
      master_ack <= 1'b0;
      ptr_hi     <= 8'h00;
      ptr        <= '0;
      ptr_set    <= 1'b0;
      wcount     <= 3'h0;
      push_v     <= 1'b0;
      push_d     <= 8'h00;
      prog_req   <= 1'b0;
      flush_req  <= 1'b0;
      prog_base  <= '0;
      prog_len   <= 3'h0;
      sda_oe     <= 1'b0;
    end
    else
    begin
      push_v    <= 1'b0;
      prog_req  <= 1'b0;
      flush_req <= 1'b0;
      if (start_det)
      begin
        // a repeated start abandons any unfinished write data
        st      <= TMI_ST_RX;
        role    <= TMI_ROLE_DEV;
        bitcnt  <= 4'h0;
        sda_oe  <= 1'b0;
        ptr_set <= 1'b0;
        wcount  <= 3'h0;
        if (wcount != 3'h0)
        begin
          flush_req <= 1'b1;
        end
      end
      else if (stop_det)
      begin
        st      <= TMI_ST_IDLE;
        sda_oe  <= 1'b0;
        ptr_set <= 1'b0;
        wcount  <= 3'h0;
        if (ptr_set & len_ok & byte_writable(wr_base)
            & byte_writable(`TMI_PTR_W'(wr_base + wcount - 1'b1)))
        begin
          prog_req  <= 1'b1;
          prog_base <= wr_base;
          prog_len  <= wcount;
        end
        else if (wcount != 3'h0)
        begin
          flush_req <= 1'b1;
        end
      end
      else
      begin
        case (st)
          TMI_ST_RX:
          begin
            if (scl_rise)
            begin
              shreg  <= {shreg[6:0], sda_s2};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == 4'h8)
            begin
              st     <= TMI_ST_ACK;
              sda_oe <= 1'b1;
              case (role)
                TMI_ROLE_DEV:
                begin
                  rw <= shreg[0];
                  if (!addr_match)
                  begin
                    st     <= TMI_ST_IDLE;
                    sda_oe <= 1'b0;
                  end
                end
                TMI_ROLE_PTRH:
                begin
                  ptr_hi <= shreg;
                end
                TMI_ROLE_PTRL:
                begin
                  ptr     <= new_ptr;
                  ptr_set <= 1'b1;
                end
                TMI_ROLE_DATA:
                begin
                  // a fifth byte finds the fifo full and is dropped; the
                  // count still marks the whole write as too long
                  push_v <= fifo_in_ready;
                  push_d <= shreg;
                  if (wcount != `TMI_WCOUNT_MAX)
                  begin
                    wcount <= wcount + 3'h1;
                  end
                end
                default:
                begin
                  st <= TMI_ST_IDLE;
                end
              endcase
            end
          end
          TMI_ST_ACK:
          begin
            if (scl_fall)
            begin
              bitcnt <= 4'h0;
              if (rw)
              begin
                // first read byte comes from the stored pointer
                txb    <= rd_now;
                ptr    <= ptr_inc(ptr);
                sda_oe <= ~rd_now[7];
                bitcnt <= 4'h1;
                st     <= TMI_ST_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                st     <= TMI_ST_RX;
                if (role != TMI_ROLE_DATA)
                begin
                  role <= tmi_role_t'(role + 2'b01);
                end
              end
            end
          end
          TMI_ST_TX:
          begin
            if (scl_fall)
            begin
              if (bitcnt == 4'h8)
              begin
                sda_oe <= 1'b0;
                st     <= TMI_ST_TXACK;
              end
              else
              begin
                sda_oe <= ~txb[6];
                txb    <= {txb[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          TMI_ST_TXACK:
          begin
            if (scl_rise)
            begin
              master_ack <= ~sda_s2;
            end
            else if (scl_fall)
            begin
              if (master_ack)
              begin
                txb    <= rd_now;
                ptr    <= ptr_inc(ptr);
                sda_oe <= ~rd_now[7];
                bitcnt <= 4'h1;
                st     <= TMI_ST_TX;
              end
              else
              begin
                st <= TMI_ST_IDLE;
              end
            end
          end
          default:
          begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;

  // -----------------------------------------------------------------------
  // write data buffer
  // -----------------------------------------------------------------------
  tmi_fifo #(
    .WIDTH (8),
    .DEPTH (`TMI_FIFO_DEPTH)
  ) u_wdata (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (push_v),
    .in_ready  (fifo_in_ready),
    .in_data   (push_d),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = (pst == TMI_PG_WRITE) | (pst == TMI_PG_FLUSH);

  // -----------------------------------------------------------------------
  // programming sequencer
  // -----------------------------------------------------------------------
  // the busy window is counted from the start of programming and does not
  // depend on the length, so one and two words take equally long
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pst  <= TMI_PG_IDLE;
      pidx <= 3'h0;
      tcnt <= 24'h00_0000;
    end
    else
    begin
      case (pst)
        TMI_PG_IDLE:
        begin
          pidx <= 3'h0;
          tcnt <= 24'h00_0000;
          if (prog_req)
          begin
            pst <= TMI_PG_WRITE;
          end
          else if (flush_req)
          begin
            pst <= TMI_PG_FLUSH;
          end
        end
        TMI_PG_WRITE:
        begin
          tcnt <= tcnt + 24'h00_0001;
          if (fifo_out_valid)
          begin
            pidx <= pidx + 3'h1;
            if (pidx == prog_len - 3'h1)
            begin
              pst <= TMI_PG_WAIT;
            end
          end
        end
        TMI_PG_WAIT:
        begin
          tcnt <= tcnt + 24'h00_0001;
          if (tcnt >= 24'(PROG_CYCLES - 1))
          begin
            pst <= TMI_PG_IDLE;
          end
        end
        TMI_PG_FLUSH:
        begin
          if (!fifo_out_valid)
          begin
            pst <= TMI_PG_IDLE;
          end
        end
        default:
        begin
          pst <= TMI_PG_IDLE;
        end
      endcase
    end
  end

  // a flush of refused write data is not programming and is not shown
  assign prog_busy = (pst == TMI_PG_WRITE) | (pst == TMI_PG_WAIT);

  // -----------------------------------------------------------------------
  // memory array and slave address bits
  // -----------------------------------------------------------------------
  assign mem_we    = (pst == TMI_PG_WRITE) & fifo_out_valid;
  assign mem_waddr = `TMI_PTR_W'(prog_base + pidx);

  // contents are not reset: the array stands for non-volatile storage
  always_ff @(posedge clock)
  begin
    if (mem_we)
    begin
      mem[mem_waddr] <= fifo_out_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      addr_bits <= `TMI_ADDR_BITS_RST;
    end
    else if (mem_we && mem_waddr == `TMI_CFG_BYTE)
    begin
      addr_bits <= fifo_out_data[1:0];
    end
  end

endmodule // tmi_slave

// *** src/tmi_defines.svh ***
// constants for the two-wire tag memory slave: addresses, map limits,
// timing.  assumes a 50 MHz system clock and byte-addressed memory.
`ifndef TMI_DEFINES_SVH
`define TMI_DEFINES_SVH

// -----------------------------------------------------------------------
// addressing
// -----------------------------------------------------------------------
`define TMI_ADDR_HI        4'hD
`define TMI_ADDR_BITS_RST  2'h3
`define TMI_PTR_W          11
`define TMI_PTR_MAX        11'h07FF
`define TMI_MEM_BYTES      1088
`define TMI_MEM_LAST       11'h043F
`define TMI_CFG_BYTE       11'h0009
`define TMI_CAL_FIRST      11'h000A
`define TMI_CAL_LAST       11'h0011
`define TMI_ROM_FIRST      11'h0028
`define TMI_ROM_LAST       11'h0033
`define TMI_BLANK_BYTE     8'hFF

// -----------------------------------------------------------------------
// transfer sizes and timing
// -----------------------------------------------------------------------
`define TMI_ONE_WORD_BYTES 3'h2
`define TMI_TWO_WORD_BYTES 3'h4
`define TMI_WCOUNT_MAX     3'h7
`define TMI_FIFO_DEPTH     4
`define TMI_CLK_PERIOD_NS  20
`define TMI_PROG_TIME_NS   5000000
`define TMI_PROG_CYCLES    (`TMI_PROG_TIME_NS / `TMI_CLK_PERIOD_NS)

`endif

// *** src/tmi_pkg.sv ***
// types for the two-wire tag memory slave.
// assumes tmi_defines.svh supplies the numeric constants.
package tmi_pkg;

  typedef enum logic [2:0] {
    TMI_ST_IDLE  = 3'b000,
    TMI_ST_RX    = 3'b001,
    TMI_ST_ACK   = 3'b010,
    TMI_ST_TX    = 3'b011,
    TMI_ST_TXACK = 3'b100
  } tmi_bus_state_t;

  typedef enum logic [1:0] {
    TMI_ROLE_DEV  = 2'b00,
    TMI_ROLE_PTRH = 2'b01,
    TMI_ROLE_PTRL = 2'b10,
    TMI_ROLE_DATA = 2'b11
  } tmi_role_t;

  typedef enum logic [1:0] {
    TMI_PG_IDLE  = 2'b00,
    TMI_PG_WRITE = 2'b01,
    TMI_PG_WAIT  = 2'b10,
    TMI_PG_FLUSH = 2'b11
  } tmi_prog_state_t;

endpackage

// *** src/tmi_fifo.sv ***
// small synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tmi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,     // system clock
  input  wire logic             sys_rst,   // sync reset, active high
  input  wire logic             in_valid,  // writer offers a word
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word written
  output logic                  out_valid, // a word is held
  input  wire logic             out_ready, // reader takes the word
  output logic      [WIDTH-1:0] out_data   // oldest word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_idx];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  function automatic logic [AW-1:0] idx_next(input logic [AW-1:0] i);
    idx_next = (i == AW'(DEPTH - 1)) ? '0 : AW'(i + 1'b1);
  endfunction

  always_ff @(posedge clock)
  begin
    if (do_push)
    begin
      store[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_idx <= idx_next(wr_idx);
      end
      if (do_pop)
      begin
        rd_idx <= idx_next(rd_idx);
      end
      if (do_push & ~do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop & ~do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // tmi_fifo

// *** sim/tmi_master.sv ***
// two-wire bus master model: drives the clock and pulls the data line.
// assumes the bench resolves sda with a pull-up and feeds it back here.
`timescale 1ns/1ps
module tmi_master #(
  parameter int HALF = 61
) (
  input  wire logic clock,  // system clock
  input  wire logic sda,    // resolved data wire
  output logic      scl,    // bus clock level
  output logic      m_pull  // high while pulling data low
);
  initial
  begin
    scl    = 1'b1;
    m_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // 126 clocks a bit keeps the rate just under 400 kbit/s
  task automatic bitx(input logic b, output logic r);
    m_pull = !b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF / 2);
    r = sda;
    tick(HALF - HALF / 2);
    scl = 1'b0;
    tick(4);
  endtask

  task automatic start_c();
    m_pull = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    m_pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(4);
  endtask

  task automatic stop_c();
    m_pull = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    m_pull = 1'b0;
    tick(HALF);
  endtask

  // nine is the ninth-clock level: 1 leaves the line to the slave
  task automatic xfer(input logic [7:0] d, input logic nine,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(nine, a);
  endtask
endmodule // tmi_master

// *** sim/tmi_slave_monitor.sv ***
// checker for the two-wire tag memory slave.
// assumes it is bound onto tmi_slave and sees only its ports.
`timescale 1ns/1ps
module tmi_slave_monitor #(
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic clock,           // system clock
  input wire logic sys_rst,         // sync reset
  input wire logic scl_in,          // bus clock pin
  input wire logic sda_in,          // bus data pin
  input wire logic sda_out,         // drive value
  input wire logic sda_oe,          // data pull enable
  input wire logic dc_supply_input, // supply present
  input wire logic prog_busy        // programming
);
  logic        sda_d;
  logic [3:0]  since_stop;
  logic [31:0] busy_cnt;

  always_ff @(posedge clock)
    sda_d <= sda_in;

  // saturating count of clocks since the last stop on the pins
  always_ff @(posedge clock)
    if (sys_rst)
      since_stop <= 4'hF;
    else if (scl_in && sda_in && !sda_d)
      since_stop <= 4'h0;
    else if (since_stop != 4'hF)
      since_stop <= since_stop + 4'h1;

  always_ff @(posedge clock)
    if (sys_rst || !prog_busy)
      busy_cnt <= 32'h0000_0000;
    else
      busy_cnt <= busy_cnt + 32'h0000_0001;

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !sda_oe && !prog_busy) else $error("drive in reset");
  a_out_low: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_busy_len: assert property ($fell(prog_busy) |->
    busy_cnt >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 4)
    else $error("busy length wrong");
  a_busy_hold: assert property ($rose(prog_busy) |=> prog_busy[*8])
    else $error("busy too short");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("drive while busy");
  a_after_stop: assert property ($rose(prog_busy) |-> since_stop <= 4'hA)
    else $error("busy without stop");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved with scl high");
  a_no_supply: assert property (!dc_supply_input &&
    $past(dc_supply_input, 8) == 1'b0 |-> !sda_oe)
    else $error("drive without supply");

  c_prog: cover property ($rose(prog_busy));
  c_ack: cover property ($rose(sda_oe));
  c_unpowered: cover property (!dc_supply_input && !scl_in);
endmodule // tmi_slave_monitor

// *** sim/tb.sv ***
// self-checking bench for tmi_slave through the master model.
// assumes a pull-up on sda and a shortened programming time.
`timescale 1ns/1ps
module tb;
  localparam int unsigned PROG  = 2000;
  localparam logic [7:0]  DEV_W = 8'hDC;
  localparam logic [7:0]  DEV_R = 8'hDD;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic dc_supply_input = 1'b1;
  logic scl, m_pull, sda, sda_out, sda_oe, prog_busy;
  logic [7:0] q;
  logic a;
  int err_count = 0;
  int checked = 0;
  int n1, n2;

  assign sda = !(sda_oe | m_pull);
  always #10 clock = !clock;

  tmi_slave #(.PROG_CYCLES(PROG)) tmi_slave_i (.clock(clock),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dc_supply_input(dc_supply_input),
    .prog_busy(prog_busy));
  tmi_master tmi_master_i (.clock(clock), .sda(sda), .scl(scl),
    .m_pull(m_pull));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic addr_nak(input logic [7:0] b);
    tmi_master_i.start_c();
    tmi_master_i.xfer(b, 1'b1, q, a);
    check(16'(a), 16'h0001);
    tmi_master_i.stop_c();
  endtask

  task automatic send(input logic [7:0] b);
    tmi_master_i.xfer(b, 1'b1, q, a);
    check(16'(a), 16'h0000);
  endtask

  task automatic recv(input logic [7:0] exp, input logic nine);
    tmi_master_i.xfer(8'hFF, nine, q, a);
    check(16'(q), 16'(exp));
  endtask

  task automatic setp(input logic [15:0] p);
    tmi_master_i.start_c();
    send(DEV_W);
    send(p[15:8]);
    send(p[7:0]);
  endtask

  task automatic read_cur(input logic [7:0] exp);
    tmi_master_i.start_c();
    send(DEV_R);
    recv(exp, 1'b1);
    tmi_master_i.stop_c();
  endtask

  task automatic wait_busy(output int n);
    int i;
    n = 0;
    for (i = 0; i < 40 && prog_busy !== 1'b1; i++)
      tmi_master_i.tick(1);
    while (prog_busy === 1'b1 && n < 5000)
    begin
      tmi_master_i.tick(1);
      n++;
    end
    if (n == 0 || n >= 5000)
    begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic bad_write(input logic [15:0] p, input int nb);
    logic seen;
    seen = 1'b0;
    setp(p);
    repeat (nb) send(8'h00);
    tmi_master_i.stop_c();
    repeat (20)
    begin
      tmi_master_i.tick(1);
      seen = seen | prog_busy;
    end
    check(16'(seen), 16'h0000);
  endtask

  task automatic s_refuse();
    logic [7:0] bad [4] = '{8'hA0, 8'hD0, 8'hD8, 8'hD4};
    foreach (bad[i])
      addr_nak(bad[i]);
    dc_supply_input = 1'b0;
    addr_nak(DEV_W);
    dc_supply_input = 1'b1;
  endtask

  task automatic s_one_word();
    setp(16'hF903);
    send(8'hAA);
    send(8'hBB);
    tmi_master_i.stop_c();
    wait_busy(n1);
    setp(16'h0102);
    read_cur(8'hAA);
    read_cur(8'hBB);
  endtask

  task automatic s_two_word();
    setp(16'h0107);
    send(8'h11);
    send(8'h22);
    send(8'h33);
    send(8'h44);
    tmi_master_i.stop_c();
    wait_busy(n2);
    check(16'(n2), 16'(n1));
    setp(16'h0104);
    tmi_master_i.stop_c();
    tmi_master_i.start_c();
    send(DEV_R);
    recv(8'h11, 1'b0);
    recv(8'h22, 1'b1);
    tmi_master_i.stop_c();
    read_cur(8'h33);
    read_cur(8'h44);
  endtask

  task automatic s_bad();
    bad_write(16'h0104, 1);
    read_cur(8'h11);
    bad_write(16'h0104, 3);
    bad_write(16'h0104, 5);
    read_cur(8'h11);
    bad_write(16'h000A, 2);
    bad_write(16'h0500, 2);
    read_cur(8'hFF);
  endtask

  task automatic s_end();
    setp(16'h043E);
    send(8'h5A);
    send(8'hA5);
    tmi_master_i.stop_c();
    addr_nak(DEV_W);
    wait_busy(n1);
    setp(16'h043F);
    read_cur(8'hA5);
    read_cur(8'hFF);
    read_cur(8'hFF);
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    #1 sys_rst = 1'b0;
    tmi_master_i.tick(4);
    s_refuse();
    s_one_word();
    s_two_word();
    s_bad();
    s_end();
    complete_run();
  end
endmodule // tb

bind tmi_slave tmi_slave_monitor #(.PROG_CYCLES(PROG_CYCLES))
  tmi_slave_monitor_i (.clock(clock), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .dc_supply_input(dc_supply_input), .prog_busy(prog_busy));
